// ### rtl/dpc_clock_control_regs.vh
// Register map, field positions and reset values of the clock-control block
`ifndef DPC_CLOCK_CONTROL_REGS_VH
`define DPC_CLOCK_CONTROL_REGS_VH

`define DPC_ADDR_W            4
`define DPC_DATA_W            16

`define DPC_OFS_LOOP_A        4'h0
`define DPC_OFS_LOOP_B        4'h4
`define DPC_OFS_STATUS        4'h8

// loop_ctrl_word_a fields
`define DPC_A_PATH_BIT        0
`define DPC_A_PRE_LSB         1
`define DPC_A_PRE_MSB         3
`define DPC_A_CP_LSB          4
`define DPC_A_CP_MSB          5
`define DPC_A_REFDIV_LSB      8
`define DPC_A_REFDIV_MSB      15
`define DPC_A_RESET           16'h0000
`define DPC_A_WMASK           16'hFF3F

// loop_ctrl_word_b fields
`define DPC_B_SLEEP_BIT       0
`define DPC_B_VCO_LSB         1
`define DPC_B_VCO_MSB         6
`define DPC_B_FBDIV_LSB       8
`define DPC_B_FBDIV_MSB       15
`define DPC_B_RESET           16'h0001
`define DPC_B_WMASK           16'hFF7F

// Status fields
`define DPC_S_LOCK_BIT        0
`define DPC_S_PLLSRC_BIT      1
`define DPC_S_SLEEP_BIT       2
`define DPC_S_PREBAD_BIT      3
`define DPC_S_CP_DBL_BIT      4

// Prescaler and charge pump codes
`define DPC_PRE_MIN           3'h2
`define DPC_PRE_MAX           3'h6
`define DPC_CP_SINGLE         2'h1
`define DPC_CP_DOUBLE         2'h3

// Digital VCO model
`define DPC_FREQ_W            16
`define DPC_VCO_SHIFT         10
`define DPC_LOCK_CNT          4'h8
`define DPC_STEP_SINGLE       16'h0001
`define DPC_STEP_DOUBLE       16'h0002

`endif

// ### rtl/dpc_div.v
// Programmable pulse divider used for the reference and feedback dividers
module dpc_div (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       clr_in,
	input  wire       tick_in,
	input  wire [7:0] ratio_in,
	output reg        pulse_out
);
	reg  [7:0] count_q;
	wire [7:0] last_w;

	// Ratio zero behaves as one so the divider never stalls
	assign last_w = (ratio_in == 8'h00) ? 8'h00 : ratio_in - 8'h01;

	always @(posedge clk_in) begin
		if (rst_in || clr_in) begin
			count_q   <= 8'h00;
			pulse_out <= 1'b0;
		end else begin
			pulse_out <= 1'b0;
			if (tick_in) begin
				if (count_q >= last_w) begin
					count_q   <= 8'h00;
					pulse_out <= 1'b1;
				end else begin
					count_q <= count_q + 8'h01;
				end
			end
		end
	end
endmodule // dpc_div

// ### rtl/dpc_clock_control.v
// Clock-source selection and digital PLL model for the conversion clock domain
// Summary of operation
// RULE_01 - Conversion logic separate from data-clock write side
// RULE_02 - Path bit low: sample clock from input
// RULE_03 - Sleep bit high: PLL and VCO halted
// RULE_04 - Path bit high: sample clock from PLL
// RULE_05 - Sleep bit low: PLL and VCO run
// RULE_06 - PLL mode multiplies the reference input up
// RULE_07 - Prescaler field is plain binary, 2 to 6
// RULE_08 - Software keeps prescaler times rate in VCO range
// RULE_09 - Six-bit coarse tune shifts VCO centre
// RULE_10 - Reference divider sets phase detector rate
// RULE_11 - Feedback divider lowers phase detector rate
// RULE_12 - Software keeps detector rate below limit
// RULE_13 - Software keeps prescaler times divider 24-480
// RULE_14 - Software picks double pump above 120
// RULE_15 - Pump code 01 single, 11 double
// RULE_16 - Strobe made from feedback divider output
// RULE_17 - Software matches detector rate to strobe rate
// RULE_18 - Software picks strobe rate as documented multiple
// RULE_19 - One multiplexer feeds all conversion logic
`include "dpc_clock_control_regs.vh"

module dpc_clock_control (
	input  wire                   clk_in,
	input  wire                   rst_in,
	input  wire                   conversion_clock_in,
	input  wire                   input_data_clock_in,
	input  wire [`DPC_ADDR_W-1:0] addr_in,
	input  wire [`DPC_DATA_W-1:0] wr_data_in,
	input  wire                   wr_en_in,
	input  wire                   rd_en_in,
	output reg  [`DPC_DATA_W-1:0] rd_data_out,
	output reg                    sample_tick_out,
	output reg                    write_tick_out,
	output reg                    output_strobe_out,
	output reg                    pll_source_out,
	output reg                    pll_sleep_out,
	output reg  [2:0]             prescale_div_out,
	output reg  [1:0]             charge_pump_sel_out,
	output reg                    locked_out
);
	reg  [`DPC_DATA_W-1:0] loop_ctrl_word_a_q;
	reg  [`DPC_DATA_W-1:0] loop_ctrl_word_b_q;
	reg                    conv_prev_q;
	reg                    data_prev_q;
	reg  [`DPC_FREQ_W-1:0] freq_q;
	reg  [`DPC_FREQ_W-1:0] freq_d;
	reg  [`DPC_FREQ_W-1:0] phase_q;
	reg                    dco_tick_q;
	reg                    reload_q;
	reg  signed [2:0]      balance_q;
	reg  signed [2:0]      balance_d;
	reg  [3:0]             lock_cnt_q;
	reg  [3:0]             lock_cnt_d;
	reg  [`DPC_FREQ_W-1:0] step_w;

	wire                   path_pll_w;
	wire                   sleep_w;
	wire [2:0]             pre_code_w;
	wire [1:0]             cp_code_w;
	wire [7:0]             ref_div_w;
	wire [7:0]             fb_div_w;
	wire [5:0]             vco_coarse_w;
	wire                   pre_bad_w;
	wire                   ref_tick_w;
	wire                   data_tick_w;
	wire                   pll_run_w;
	wire                   sel_tick_w;
	wire                   pfd_ref_w;
	wire                   pfd_fb_w;
	wire [`DPC_FREQ_W:0]   phase_sum_w;
	wire [`DPC_FREQ_W-1:0] centre_w;
	wire                   wr_a_w;
	wire                   wr_b_w;

	assign path_pll_w   = loop_ctrl_word_a_q[`DPC_A_PATH_BIT];
	assign pre_code_w   = loop_ctrl_word_a_q[`DPC_A_PRE_MSB:`DPC_A_PRE_LSB];
	assign cp_code_w    = loop_ctrl_word_a_q[`DPC_A_CP_MSB:`DPC_A_CP_LSB];
	assign ref_div_w    = loop_ctrl_word_a_q[`DPC_A_REFDIV_MSB:`DPC_A_REFDIV_LSB];
	assign sleep_w      = loop_ctrl_word_b_q[`DPC_B_SLEEP_BIT];
	assign vco_coarse_w = loop_ctrl_word_b_q[`DPC_B_VCO_MSB:`DPC_B_VCO_LSB];
	assign fb_div_w     = loop_ctrl_word_b_q[`DPC_B_FBDIV_MSB:`DPC_B_FBDIV_LSB];

	assign wr_a_w = wr_en_in && (addr_in == `DPC_OFS_LOOP_A);
	assign wr_b_w = wr_en_in && (addr_in == `DPC_OFS_LOOP_B);

	// RULE_07 prescaler code range
	assign pre_bad_w = (pre_code_w < `DPC_PRE_MIN) || (pre_code_w > `DPC_PRE_MAX);

	// Inputs are synchronous, so a plain edge detector gives the ticks
	assign ref_tick_w  = conversion_clock_in && !conv_prev_q;
	assign data_tick_w = input_data_clock_in && !data_prev_q;

	// RULE_03 sleep halts loop
	// RULE_05 awake loop runs
	assign pll_run_w = !sleep_w;

	// RULE_02 bypass uses input
	// RULE_04 PLL path selected
	// RULE_19 single source mux
	assign sel_tick_w = path_pll_w ? dco_tick_q : ref_tick_w;

	// RULE_09 coarse tune centre
	assign centre_w    = {vco_coarse_w, {`DPC_VCO_SHIFT{1'b0}}};
	assign phase_sum_w = {1'b0, phase_q} + {1'b0, freq_q};

	always @(posedge clk_in) begin
		if (rst_in) begin
			loop_ctrl_word_a_q <= `DPC_A_RESET;
			loop_ctrl_word_b_q <= `DPC_B_RESET;
		end else begin
			if (wr_a_w) begin
				loop_ctrl_word_a_q <= wr_data_in & `DPC_A_WMASK;
			end
			if (wr_b_w) begin
				loop_ctrl_word_b_q <= wr_data_in & `DPC_B_WMASK;
			end
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			rd_data_out <= {`DPC_DATA_W{1'b0}};
		end else if (rd_en_in) begin
			case (addr_in)
				`DPC_OFS_LOOP_A: begin
					rd_data_out <= loop_ctrl_word_a_q;
				end
				`DPC_OFS_LOOP_B: begin
					rd_data_out <= loop_ctrl_word_b_q;
				end
				`DPC_OFS_STATUS: begin
					rd_data_out <= {11'h000,
						cp_code_w == `DPC_CP_DOUBLE,
						pre_bad_w,
						sleep_w,
						path_pll_w,
						locked_out};
				end
				default: begin
					rd_data_out <= {`DPC_DATA_W{1'b0}};
				end
			endcase
		end else begin
			rd_data_out <= {`DPC_DATA_W{1'b0}};
		end
	end

	// RULE_10 reference divider
	dpc_div u_ref_div (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.clr_in    (sleep_w),
		.tick_in   (ref_tick_w),
		.ratio_in  (ref_div_w),
		.pulse_out (pfd_ref_w)
	);

	// RULE_11 feedback divider
	dpc_div u_fb_div (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.clr_in    (sleep_w),
		.tick_in   (dco_tick_q),
		.ratio_in  (fb_div_w),
		.pulse_out (pfd_fb_w)
	);

	// RULE_15 pump strength step
	always @* begin
		case (cp_code_w)
			`DPC_CP_SINGLE: begin
				step_w = `DPC_STEP_SINGLE;
			end
			`DPC_CP_DOUBLE: begin
				step_w = `DPC_STEP_DOUBLE;
			end
			default: begin
				step_w = {`DPC_FREQ_W{1'b0}};
			end
		endcase
	end

	// RULE_06 loop pulls VCO up or down
	always @* begin
		freq_d    = freq_q;
		balance_d = balance_q;
		lock_cnt_d = lock_cnt_q;
		if (pfd_ref_w && !pfd_fb_w) begin
			// Hold rather than wrap, a wrap would look like a huge step
			if (freq_q <= ~step_w) begin
				freq_d = freq_q + step_w;
			end
			if (balance_q != 3'sd3) begin
				balance_d = balance_q + 3'sd1;
			end
		end else if (pfd_fb_w && !pfd_ref_w) begin
			if (freq_q >= step_w) begin
				freq_d = freq_q - step_w;
			end
			if (balance_q != -3'sd3) begin
				balance_d = balance_q - 3'sd1;
			end
		end
		if (pfd_ref_w || pfd_fb_w) begin
			if ((balance_d > 3'sd1) || (balance_d < -3'sd1)) begin
				lock_cnt_d = 4'h0;
			end else if (lock_cnt_q != `DPC_LOCK_CNT) begin
				lock_cnt_d = lock_cnt_q + 4'h1;
			end
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			freq_q     <= {`DPC_FREQ_W{1'b0}};
			phase_q    <= {`DPC_FREQ_W{1'b0}};
			dco_tick_q <= 1'b0;
			reload_q   <= 1'b1;
			balance_q  <= 3'sd0;
			lock_cnt_q <= 4'h0;
		end else if (!pll_run_w) begin
			// Sleeping loop loses lock and restarts from the centre
			phase_q    <= {`DPC_FREQ_W{1'b0}};
			dco_tick_q <= 1'b0;
			reload_q   <= 1'b1;
			balance_q  <= 3'sd0;
			lock_cnt_q <= 4'h0;
		end else if (reload_q || wr_b_w) begin
			freq_q     <= centre_w;
			dco_tick_q <= 1'b0;
			reload_q   <= 1'b0;
			balance_q  <= 3'sd0;
			lock_cnt_q <= 4'h0;
		end else begin
			freq_q     <= freq_d;
			phase_q    <= phase_sum_w[`DPC_FREQ_W-1:0];
			dco_tick_q <= phase_sum_w[`DPC_FREQ_W];
			balance_q  <= balance_d;
			lock_cnt_q <= lock_cnt_d;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			// Track the pins in reset, a stale low would fake an edge
			conv_prev_q         <= conversion_clock_in;
			data_prev_q         <= input_data_clock_in;
			sample_tick_out     <= 1'b0;
			write_tick_out      <= 1'b0;
			output_strobe_out   <= 1'b0;
			pll_source_out      <= 1'b0;
			pll_sleep_out       <= 1'b1;
			prescale_div_out    <= 3'h0;
			charge_pump_sel_out <= 2'h0;
			locked_out          <= 1'b0;
		end else begin
			conv_prev_q         <= conversion_clock_in;
			data_prev_q         <= input_data_clock_in;
			// RULE_19 conversion domain tick
			sample_tick_out     <= sel_tick_w;
			// RULE_01 write side tick
			write_tick_out      <= data_tick_w;
			// RULE_16 strobe from feedback
			output_strobe_out   <= path_pll_w && pll_run_w && pfd_fb_w;
			pll_source_out      <= path_pll_w;
			pll_sleep_out       <= sleep_w;
			// RULE_07 binary divider value
			prescale_div_out    <= pre_code_w;
			charge_pump_sel_out <= cp_code_w;
			locked_out          <= pll_run_w && (lock_cnt_d == `DPC_LOCK_CNT);
		end
	end
endmodule // dpc_clock_control

// ### verif/dpc_clk_src.sv
// Reference clock and input data clock source model
module dpc_clk_src (
	input  logic       clk_in,
	input  logic [3:0] half_in,
	output logic       ref_out = 1'b0,
	output logic       data_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q = 4'h0;
	logic [1:0] dcnt_q = 2'h0;
	always @(posedge clk_in) begin
		cnt_q <= (cnt_q >= half_in) ? 4'h0 : cnt_q + 4'h1;
		if (cnt_q >= half_in)
			ref_out <= ~ref_out;
	end
	always @(posedge clk_in) begin
		dcnt_q <= dcnt_q + 2'h1;
		if (dcnt_q == 2'h3)
			data_out <= ~data_out;
	end
endmodule // dpc_clk_src

// ### verif/dpc_clock_control_properties.sv
// Port-level assertions for the clock-control block
`include "dpc_clock_control_regs.vh"
module dpc_clock_control_properties (
	input logic                   clk_in,
	input logic                   rst_in,
	input logic                   conversion_clock_in,
	input logic                   input_data_clock_in,
	input logic                   rd_en_in,
	input logic [`DPC_DATA_W-1:0] rd_data_out,
	input logic                   sample_tick_out,
	input logic                   write_tick_out,
	input logic                   output_strobe_out,
	input logic                   pll_source_out,
	input logic                   pll_sleep_out,
	input logic                   locked_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_asleep;
		pll_sleep_out ##1 pll_sleep_out;
	endsequence
	reset_state_a: assert property (disable iff (1'b0)
		rst_in |=> pll_sleep_out && !pll_source_out && !locked_out && rd_data_out == 16'h0000)
		else $error("Reset state wrong");
	bypass_tick_a: assert property (
		$rose(conversion_clock_in) && !pll_source_out |=> sample_tick_out || pll_source_out)
		else $error("Bypass tick missing");
	bypass_only_a: assert property (
		sample_tick_out && !pll_source_out && !$past(pll_source_out)
		|-> $past(conversion_clock_in) && !$past(conversion_clock_in, 2))
		else $error("Bypass tick without edge");
	data_tick_a: assert property (
		$rose(input_data_clock_in) |-> ##1 write_tick_out) else $error("Write tick missing");
	rd_idle_a: assert property (
		!$past(rd_en_in) |-> rd_data_out == 16'h0000) else $error("Read data not idle");
	sleep_quiet_a: assert property (
		s_asleep |-> !output_strobe_out && !locked_out) else $error("Activity while asleep");
	sleep_tick_a: assert property (
		(pll_source_out && pll_sleep_out) [*3] |-> !sample_tick_out)
		else $error("PLL tick while asleep");
	strobe_src_a: assert property (
		output_strobe_out |-> pll_source_out || $past(pll_source_out))
		else $error("Strobe outside PLL mode");
endmodule // dpc_clock_control_properties
bind dpc_clock_control dpc_clock_control_properties u_props (.clk_in(clk_in), .rst_in(rst_in),
	.conversion_clock_in(conversion_clock_in), .input_data_clock_in(input_data_clock_in),
	.rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .sample_tick_out(sample_tick_out),
	.write_tick_out(write_tick_out), .output_strobe_out(output_strobe_out),
	.pll_source_out(pll_source_out), .pll_sleep_out(pll_sleep_out), .locked_out(locked_out));

// ### verif/dpc_clock_control_tb_top.sv
// Self-checking bench for the clock-control block
module dpc_clock_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [3:0]  addr_in = 4'h0;
	logic [15:0] wr_data_in = 16'h0000;
	logic        wr_en_in = 1'b0;
	logic        rd_en_in = 1'b0;
	logic [3:0]  half_q = 4'h2;
	logic [2:0]  ref_sh_q = 3'h0;
	logic [2:0]  dat_sh_q = 3'h0;
	logic        conv, dclk, smp, wt, str, src, slp, lck;
	logic [15:0] rd_data;
	logic [2:0]  pre;
	logic [1:0]  cp;
	int          num_errors = 0;
	int          comparisons = 0;
	int          n_ref = 0, n_dat = 0, n_smp = 0, n_wt = 0, n_str = 0;
	int          d_ref, d_dat, d_smp, d_wt, d_str;
	always #20 clk_in = ~clk_in;
	dpc_clk_src src_m (.clk_in(clk_in), .half_in(half_q), .ref_out(conv), .data_out(dclk));
	dpc_clock_control dut (.clk_in(clk_in), .rst_in(rst_in), .conversion_clock_in(conv),
		.input_data_clock_in(dclk), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data),
		.sample_tick_out(smp), .write_tick_out(wt), .output_strobe_out(str),
		.pll_source_out(src), .pll_sleep_out(slp), .prescale_div_out(pre),
		.charge_pump_sel_out(cp), .locked_out(lck));
	// Reference edge count delayed to line up with the tick latency, data edge count one cycle later
	always @(posedge clk_in) begin
		ref_sh_q <= {ref_sh_q[1:0], conv};
		dat_sh_q <= {dat_sh_q[1:0], dclk};
		n_ref <= n_ref + (ref_sh_q[0] && !ref_sh_q[1]);
		n_dat <= n_dat + (dat_sh_q[1] && !dat_sh_q[2]);
		n_smp <= n_smp + smp;
		n_wt <= n_wt + wt;
		n_str <= n_str + str;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk(rd_data, e);
	endtask
	task automatic win(input int n);
		int r0, a0, s0, w0, t0;
		r0 = n_ref;
		a0 = n_dat;
		s0 = n_smp;
		w0 = n_wt;
		t0 = n_str;
		repeat (n) @(posedge clk_in);
		d_ref = n_ref - r0;
		d_dat = n_dat - a0;
		d_smp = n_smp - s0;
		d_wt = n_wt - w0;
		d_str = n_str - t0;
	endtask
	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk({15'h0, slp}, 16'h0001);
		chk({9'h000, src, lck, pre, cp}, 16'h0000);
		rd(4'h0, 16'h0000);
		rd(4'h8, 16'h000C);
		wr(4'hC, 16'hFFFF);
		rd(4'hC, 16'h0000);
		rd(4'h4, 16'h0001);
		$display("test reset done");
		// Fast and slow reference in bypass
		for (int h = 1; h < 7; h += 4) begin
			half_q <= 4'(h);
			win(20);
			win(120);
			chk(16'(d_smp), 16'(d_ref));
			chk(16'(d_str), 16'h0000);
			chk(16'(d_wt), 16'(d_dat));
		end
		$display("test bypass done");
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, {8'h04, 2'b00, 2'(i), 3'(i), 1'b0});
			repeat (2) @(posedge clk_in);
			#1;
			chk({13'h0, pre}, 16'(i));
			chk({14'h0, cp}, 16'(i % 4));
			rd(4'h0, {8'h04, 2'b00, 2'(i), 3'(i), 1'b0});
			rd(4'h8, {11'h0, i % 4 == 3, i < 2 || i == 7, 3'h4});
		end
		$display("test fields done");
		half_q <= 4'h2;
		// Loop multiplies the reference by 16 over 4
		// detector rate is strobe
		wr(4'h4, 16'h1056);
		wr(4'h0, 16'h041D);
		win(200);
		win(240);
		chk({15'h0, src && !slp}, 16'h0001);
		chk({15'h0, d_smp >= 4 * d_ref - 5 && d_smp <= 4 * d_ref + 5}, 16'h0001);
		chk({15'h0, d_str >= d_ref / 4 - 2 && d_str <= d_ref / 4 + 2}, 16'h0001);
		chk({15'h0, lck}, 16'h0001);
		$display("test pll done");
		wr(4'h4, 16'h1057);
		win(4);
		win(100);
		chk(16'(d_smp + d_str), 16'h0000);
		rd(4'h8, 16'h0006);
		$display("test sleep done");
		give_verdict();
	end
endmodule // dpc_clock_control_tb_top
